/* hdl/lmnsr_regs.sv */
// lock monitor, nonvolatile memory control and status register bank
// assumes a same-clock register port and a same-clock nonvolatile memory engine; fault flags are async pins
//
// Overview of operation
// - set threshold upper nibble codes 0..10 select 0.1 to 10000 ppm logarithmically
// - clear threshold upper nibble uses the same code table as set threshold
// - timer enable bit 1 switches the lock-loss timer on or off
// - bank write count reads 0, 3, 15, 63 for zero to three burns
// - writing 0xC7 to the burn command register starts a bank burn until three burns are done
// - setting reload bit 0 copies nonvolatile contents into the configuration
// - extend enable bit 5 keeps wide bandwidth past lock clear, resets to 1
// - extension length is 29 bits over four bytes, low byte first
// - device ready byte reads 0x0F only when registers are safe to access
// - device ready byte appears at the same offset on every page
// - global output bit 0 low forces all drivers off, high passes enables
// - detector enable bit 1 turns the slow detector on; the timer enable acts only then
`timescale 1ns/10ps

module lmnsr_regs
    import lmnsr_pkg::*;
#(
    parameter int NUM_OUTPUTS = 10
)
(
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    // register port
    input  wire logic [`LMNSR_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata,
    // nonvolatile memory engine
    output logic                           nvm_burn_start,
    input  wire logic                      nvm_burn_done,
    output logic                           nvm_reload_start,
    input  wire logic                      nvm_load_valid,
    input  wire logic [`LMNSR_ADDR_W-1:0]  nvm_load_addr,
    input  wire logic [7:0]                nvm_load_data,
    input  wire logic                      nvm_reload_done,
    // fault flag pins
    input  wire lmnsr_fault_t              fault_in,
    // loop settings
    output logic                           slow_unlock_detector_on,
    output logic                           unlock_timer_on,
    output logic      [1:0]                value_window,
    output logic      [`LMNSR_PPM_W-1:0]   set_threshold_tenth_ppm,
    output logic      [`LMNSR_PPM_W-1:0]   clear_threshold_tenth_ppm,
    output logic      [`LMNSR_LEN_W-1:0]   unlock_clear_delay,
    output logic                           fast_acquire_extend_on,
    output logic      [`LMNSR_LEN_W-1:0]   fast_acquire_extend_len,
    // output drivers
    input  wire logic [NUM_OUTPUTS-1:0]    drv_enable_in,
    output logic      [NUM_OUTPUTS-1:0]    drv_enable_out,
    // interrupt
    output logic                           irq
);

    typedef struct packed {
        lmnsr_cfg_t              cfg;
        lmnsr_nvm_e_t            nvm;
        logic [1:0]              burns;
        logic                    reload_req;
        logic                    burn_start;
        logic                    reload_start;
        logic                    timer_active;
        logic [`LMNSR_PPM_W-1:0] set_ppm;
        logic [`LMNSR_PPM_W-1:0] clear_ppm;
        lmnsr_fault_t            flag_meta;
        lmnsr_fault_t            flag_sync;
        lmnsr_fault_t            flag_prev;
        logic [3:0]              irq_status;
        logic [3:0]              irq_mask;
        logic [7:0]              rd_data;
    } lmnsr_state_t;

    lmnsr_state_t            st;
    lmnsr_state_t            next_st;
    logic [`LMNSR_PPM_W-1:0] set_dec;
    logic [`LMNSR_PPM_W-1:0] clear_dec;
    logic [2:0]              summary;
    logic [7:0]              sys_byte;
    logic [7:0]              lock_byte;
    logic                    idle;

    // decoders read the next configuration so the decoded thresholds are registered
    lmnsr_ppm_decode u_set_decode
    (
        .code      (next_st.cfg.set_code),
        .tenth_ppm (set_dec)
    );

    lmnsr_ppm_decode u_clear_decode
    (
        .code      (next_st.cfg.clear_code),
        .tenth_ppm (clear_dec)
    );

    function automatic lmnsr_cfg_t cfg_write(lmnsr_cfg_t c, logic [`LMNSR_ADDR_W-1:0] a, logic [7:0] d);
        lmnsr_cfg_t r;
        r = c;
        if (a == `LMNSR_OFS_DET_ON)
            r.detector_on = d[`LMNSR_BIT_DET_ON];
        else if (a == `LMNSR_OFS_VALWIN)
            r.value_window = d[3:2];
        else if (a == `LMNSR_OFS_SET_THR)
            r.set_code = d[7:4];
        else if (a == `LMNSR_OFS_CLR_THR)
            r.clear_code = d[7:4];
        else if (a == `LMNSR_OFS_TIMER)
            r.timer_on = d[`LMNSR_BIT_TIMER];
        else if (a == `LMNSR_OFS_DELAY0)
            r.clear_delay[7:0] = d;
        else if (a == `LMNSR_OFS_DELAY1)
            r.clear_delay[15:8] = d;
        else if (a == `LMNSR_OFS_DELAY2)
            r.clear_delay[23:16] = d;
        else if (a == `LMNSR_OFS_DELAY3)
            r.clear_delay[28:24] = d[4:0];
        else if (a == `LMNSR_OFS_EXT_EN)
            r.extend_on = d[`LMNSR_BIT_EXT_EN];
        else if (a == `LMNSR_OFS_EXT0)
            r.extend_len[7:0] = d;
        else if (a == `LMNSR_OFS_EXT1)
            r.extend_len[15:8] = d;
        else if (a == `LMNSR_OFS_EXT2)
            r.extend_len[23:16] = d;
        else if (a == `LMNSR_OFS_EXT3)
            r.extend_len[28:24] = d[4:0];
        else if (a == `LMNSR_OFS_OUT_KILL)
            r.out_pass = d[`LMNSR_BIT_OUT_PASS];
        return r;
    endfunction : cfg_write

    always_comb
    begin
        idle      = (st.nvm == LMNSR_IDLE);
        sys_byte  = {2'h0, st.flag_sync.sys[4:3], 1'b0, st.flag_sync.sys[2:0]};
        lock_byte = {2'h0, st.flag_sync.holdover, 3'h0, st.flag_sync.unlock, 1'b0};
        summary   = {|lock_byte, |{st.flag_sync.freq_fault, st.flag_sync.missing}, |sys_byte};
    end

    always_comb
    begin
        next_st              = st;
        next_st.burn_start   = 1'b0;
        next_st.reload_start = 1'b0;
        next_st.flag_meta    = fault_in;
        next_st.flag_sync    = st.flag_meta;
        next_st.flag_prev    = st.flag_sync;

        // configuration writes are ignored while the memory engine owns the registers
        if (reg_wr && idle)
            next_st.cfg = cfg_write(st.cfg, reg_addr, reg_wdata);

        case (st.nvm)
            LMNSR_IDLE:
            begin
                if (reg_wr && reg_addr == `LMNSR_OFS_BURN && reg_wdata == `LMNSR_BURN_KEY
                    && st.burns != `LMNSR_MAX_BURNS)
                begin
                    next_st.burn_start = 1'b1;
                    next_st.nvm        = LMNSR_BURNING;
                end
                else if (reg_wr && reg_addr == `LMNSR_OFS_RELOAD && reg_wdata[`LMNSR_BIT_RELOAD])
                begin
                    next_st.reload_req   = 1'b1;
                    next_st.reload_start = 1'b1;
                    next_st.nvm          = LMNSR_RELOADING;
                end
            end
            LMNSR_BURNING:
            begin
                if (nvm_burn_done)
                begin
                    next_st.burns = st.burns + 2'h1;
                    next_st.nvm   = LMNSR_IDLE;
                end
            end
            LMNSR_RELOADING:
            begin
                if (nvm_load_valid)
                    next_st.cfg = cfg_write(st.cfg, nvm_load_addr, nvm_load_data);
                if (nvm_reload_done)
                begin
                    next_st.reload_req = 1'b0;
                    next_st.nvm        = LMNSR_IDLE;
                end
            end
            default:
                next_st.nvm = LMNSR_IDLE;
        endcase

        // the timer enable only reaches the loop while the slow detector is on
        next_st.timer_active = next_st.cfg.timer_on && next_st.cfg.detector_on;
        next_st.set_ppm      = set_dec;
        next_st.clear_ppm    = clear_dec;

        if (reg_wr && reg_addr == `LMNSR_OFS_IRQ_MASK)
            next_st.irq_mask = reg_wdata[3:0];
        // clear first, so that an event in the same cycle wins over the clear
        if (reg_wr && reg_addr == `LMNSR_OFS_IRQ_STAT)
            next_st.irq_status = st.irq_status & ~reg_wdata[3:0];
        if (st.nvm == LMNSR_BURNING && nvm_burn_done)
            next_st.irq_status[0] = 1'b1;
        if (st.nvm == LMNSR_RELOADING && nvm_reload_done)
            next_st.irq_status[1] = 1'b1;
        if (st.flag_sync.unlock && !st.flag_prev.unlock)
            next_st.irq_status[2] = 1'b1;
        if (|(st.flag_sync & ~st.flag_prev))
            next_st.irq_status[3] = 1'b1;

        next_st.rd_data = 8'h00;
        if (reg_rd)
        begin
            // the ready byte is decoded on the low byte only, so it answers on any page
            if (reg_addr[7:0] == `LMNSR_READY_LOW)
                next_st.rd_data = idle ? `LMNSR_READY_VAL : `LMNSR_NOT_READY;
            else if (reg_addr == `LMNSR_OFS_DET_ON)
                next_st.rd_data = 8'(st.cfg.detector_on) << `LMNSR_BIT_DET_ON;
            else if (reg_addr == `LMNSR_OFS_VALWIN)
                next_st.rd_data = {4'h0, st.cfg.value_window, 2'h0};
            else if (reg_addr == `LMNSR_OFS_SET_THR)
                next_st.rd_data = {st.cfg.set_code, 4'h0};
            else if (reg_addr == `LMNSR_OFS_CLR_THR)
                next_st.rd_data = {st.cfg.clear_code, 4'h0};
            else if (reg_addr == `LMNSR_OFS_TIMER)
                next_st.rd_data = 8'(st.cfg.timer_on) << `LMNSR_BIT_TIMER;
            else if (reg_addr == `LMNSR_OFS_DELAY0)
                next_st.rd_data = st.cfg.clear_delay[7:0];
            else if (reg_addr == `LMNSR_OFS_DELAY1)
                next_st.rd_data = st.cfg.clear_delay[15:8];
            else if (reg_addr == `LMNSR_OFS_DELAY2)
                next_st.rd_data = st.cfg.clear_delay[23:16];
            else if (reg_addr == `LMNSR_OFS_DELAY3)
                next_st.rd_data = {3'h0, st.cfg.clear_delay[28:24]};
            else if (reg_addr == `LMNSR_OFS_BANK_CNT)
            begin
                case (st.burns)
                    2'h0:    next_st.rd_data = `LMNSR_BANKS_0;
                    2'h1:    next_st.rd_data = `LMNSR_BANKS_1;
                    2'h2:    next_st.rd_data = `LMNSR_BANKS_2;
                    default: next_st.rd_data = `LMNSR_BANKS_3;
                endcase
            end
            else if (reg_addr == `LMNSR_OFS_RELOAD)
                next_st.rd_data = 8'(st.reload_req) << `LMNSR_BIT_RELOAD;
            else if (reg_addr == `LMNSR_OFS_EXT_EN)
                next_st.rd_data = 8'(st.cfg.extend_on) << `LMNSR_BIT_EXT_EN;
            else if (reg_addr == `LMNSR_OFS_EXT0)
                next_st.rd_data = st.cfg.extend_len[7:0];
            else if (reg_addr == `LMNSR_OFS_EXT1)
                next_st.rd_data = st.cfg.extend_len[15:8];
            else if (reg_addr == `LMNSR_OFS_EXT2)
                next_st.rd_data = st.cfg.extend_len[23:16];
            else if (reg_addr == `LMNSR_OFS_EXT3)
                next_st.rd_data = {3'h0, st.cfg.extend_len[28:24]};
            else if (reg_addr == `LMNSR_OFS_SUMMARY)
                next_st.rd_data = {5'h00, summary};
            else if (reg_addr == `LMNSR_OFS_SYS_FLAGS)
                next_st.rd_data = sys_byte;
            else if (reg_addr == `LMNSR_OFS_IN_FLAGS)
                next_st.rd_data = {st.flag_sync.freq_fault, st.flag_sync.missing};
            else if (reg_addr == `LMNSR_OFS_LOCK_FLAGS)
                next_st.rd_data = lock_byte;
            else if (reg_addr == `LMNSR_OFS_OUT_KILL)
                next_st.rd_data = 8'(st.cfg.out_pass) << `LMNSR_BIT_OUT_PASS;
            else if (reg_addr == `LMNSR_OFS_IRQ_STAT)
                next_st.rd_data = {4'h0, st.irq_status};
            else if (reg_addr == `LMNSR_OFS_IRQ_MASK)
                next_st.rd_data = {4'h0, st.irq_mask};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            st               <= '0;
            st.nvm           <= LMNSR_IDLE;
            st.cfg.extend_on <= `LMNSR_EXT_EN_RST;
            st.cfg.out_pass  <= `LMNSR_OUT_PASS_RST;
            st.set_ppm       <= 17'h00001;
            st.clear_ppm     <= 17'h00001;
        end
        else
            st <= next_st;
    end

    assign reg_rdata                 = st.rd_data;
    assign nvm_burn_start            = st.burn_start;
    assign nvm_reload_start          = st.reload_start;
    assign slow_unlock_detector_on   = st.cfg.detector_on;
    assign unlock_timer_on           = st.timer_active;
    assign value_window              = st.cfg.value_window;
    assign set_threshold_tenth_ppm   = st.set_ppm;
    assign clear_threshold_tenth_ppm = st.clear_ppm;
    assign unlock_clear_delay        = st.cfg.clear_delay;
    assign fast_acquire_extend_on    = st.cfg.extend_on;
    assign fast_acquire_extend_len   = st.cfg.extend_len;
    // kept combinational so a driver enable change is not delayed a cycle
    assign drv_enable_out            = drv_enable_in & {NUM_OUTPUTS{st.cfg.out_pass}};
    assign irq                       = |(st.irq_status & st.irq_mask);

    property p_set_decode;
        @(posedge ref_clk) disable iff (reset)
        (st.cfg.set_code == 4'h4) |-> (set_threshold_tenth_ppm == 17'h00064);
    endproperty
    a_set_decode: assert property (p_set_decode) else $error("set code 4 is not 10 ppm");

    property p_clear_decode;
        @(posedge ref_clk) disable iff (reset)
        (st.cfg.clear_code == 4'hA) |-> (clear_threshold_tenth_ppm == 17'h186A0);
    endproperty
    a_clear_decode: assert property (p_clear_decode) else $error("clear code 10 is not 10000 ppm");

    property p_timer_gate;
        @(posedge ref_clk) disable iff (reset)
        unlock_timer_on |-> (st.cfg.timer_on && slow_unlock_detector_on);
    endproperty
    a_timer_gate: assert property (p_timer_gate) else $error("timer on without enable or detector");

    property p_bank_count;
        @(posedge ref_clk) disable iff (reset)
        (reg_rd && reg_addr == `LMNSR_OFS_BANK_CNT && st.burns == 2'h2) |=> (reg_rdata == 8'h0F);
    endproperty
    a_bank_count: assert property (p_bank_count) else $error("two burns do not read 15");

    property p_burn_start;
        @(posedge ref_clk) disable iff (reset)
        (reg_wr && reg_addr == `LMNSR_OFS_BURN && reg_wdata == 8'hC7 && idle && st.burns != 2'h3)
            |=> (nvm_burn_start ##1 !nvm_burn_start);
    endproperty
    a_burn_start: assert property (p_burn_start) else $error("burn key did not give one start pulse");

    property p_reload_start;
        @(posedge ref_clk) disable iff (reset)
        (reg_wr && reg_addr == `LMNSR_OFS_RELOAD && reg_wdata[0] && idle)
            |=> (nvm_reload_start && st.reload_req);
    endproperty
    a_reload_start: assert property (p_reload_start) else $error("reload bit did not start a copy");

    property p_reload_clear;
        @(posedge ref_clk) disable iff (reset)
        $fell(st.reload_req) |-> $past(nvm_reload_done);
    endproperty
    a_reload_clear: assert property (p_reload_clear) else $error("reload bit cleared without done");

    property p_extend_reset;
        @(posedge ref_clk)
        $fell(reset) |-> fast_acquire_extend_on;
    endproperty
    a_extend_reset: assert property (p_extend_reset) else $error("extend enable not 1 after reset");

    property p_extend_top;
        @(posedge ref_clk) disable iff (reset)
        (reg_wr && idle && reg_addr == `LMNSR_OFS_EXT3) |=> (fast_acquire_extend_len[28:24] == $past(reg_wdata[4:0]));
    endproperty
    a_extend_top: assert property (p_extend_top) else $error("extension top byte not in bits 28:24");

    property p_ready_busy;
        @(posedge ref_clk) disable iff (reset)
        (reg_rd && reg_addr[7:0] == 8'hFE && !idle) |=> (reg_rdata == 8'h00);
    endproperty
    a_ready_busy: assert property (p_ready_busy) else $error("ready byte shows 0x0F while busy");

    property p_ready_page;
        @(posedge ref_clk) disable iff (reset)
        (reg_rd && reg_addr[7:0] == 8'hFE && idle) |=> (reg_rdata == 8'h0F);
    endproperty
    a_ready_page: assert property (p_ready_page) else $error("ready byte missing on this page");

    property p_output_kill;
        @(posedge ref_clk) disable iff (reset)
        !st.cfg.out_pass |-> (drv_enable_out == '0);
    endproperty
    a_output_kill: assert property (p_output_kill) else $error("driver enabled while all outputs off");

    property p_summary;
        @(posedge ref_clk) disable iff (reset)
        (reg_rd && reg_addr == `LMNSR_OFS_SUMMARY) |=> (reg_rdata[0] == $past(|st.flag_sync.sys));
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit 0 disagrees with system flags");

endmodule : lmnsr_regs

/* include/lmnsr_params.svh */
// offsets, field positions, reset values and codes of the lock monitor register bank
// assumes a 16-bit register address whose upper byte is the page and lower byte the in-page offset
`ifndef LMNSR_PARAMS_SVH
`define LMNSR_PARAMS_SVH

`define LMNSR_ADDR_W        16
`define LMNSR_PPM_W         17
`define LMNSR_LEN_W         29

`define LMNSR_OFS_DET_ON    16'h009A
`define LMNSR_OFS_VALWIN    16'h009D
`define LMNSR_OFS_SET_THR   16'h009E
`define LMNSR_OFS_CLR_THR   16'h00A0
`define LMNSR_OFS_TIMER     16'h00A2
`define LMNSR_OFS_DELAY0    16'h00A9
`define LMNSR_OFS_DELAY1    16'h00AA
`define LMNSR_OFS_DELAY2    16'h00AB
`define LMNSR_OFS_DELAY3    16'h00AC
`define LMNSR_OFS_BANK_CNT  16'h00E2
`define LMNSR_OFS_BURN      16'h00E3
`define LMNSR_OFS_RELOAD    16'h00E4
`define LMNSR_OFS_EXT_EN    16'h00E5
`define LMNSR_OFS_EXT0      16'h00EA
`define LMNSR_OFS_EXT1      16'h00EB
`define LMNSR_OFS_EXT2      16'h00EC
`define LMNSR_OFS_EXT3      16'h00ED
`define LMNSR_OFS_SUMMARY   16'h00F6
`define LMNSR_OFS_SYS_FLAGS 16'h00F7
`define LMNSR_OFS_IN_FLAGS  16'h00F8
`define LMNSR_OFS_LOCK_FLAGS 16'h00F9
`define LMNSR_OFS_OUT_KILL  16'h0102
`define LMNSR_OFS_IRQ_STAT  16'h0104
`define LMNSR_OFS_IRQ_MASK  16'h0105
`define LMNSR_READY_LOW     8'hFE

`define LMNSR_BIT_DET_ON    1
`define LMNSR_BIT_TIMER     1
`define LMNSR_BIT_RELOAD    0
`define LMNSR_BIT_EXT_EN    5
`define LMNSR_BIT_OUT_PASS  0

`define LMNSR_BURN_KEY      8'hC7
`define LMNSR_READY_VAL     8'h0F
`define LMNSR_NOT_READY     8'h00
`define LMNSR_BANKS_0       8'h00
`define LMNSR_BANKS_1       8'h03
`define LMNSR_BANKS_2       8'h0F
`define LMNSR_BANKS_3       8'h3F
`define LMNSR_MAX_BURNS     2'h3
`define LMNSR_EXT_EN_RST    1'b1
`define LMNSR_OUT_PASS_RST  1'b0
`define LMNSR_MAX_CODE      4'hA

`endif

/* include/lmnsr_pkg.sv */
// types shared by the lock monitor register bank and its threshold decoder
// assumes lmnsr_params.svh is on the include path
`include "lmnsr_params.svh"

package lmnsr_pkg;

    typedef enum logic [1:0] {LMNSR_IDLE, LMNSR_BURNING, LMNSR_RELOADING} lmnsr_nvm_e_t;

    // one bundle of fault flags, as seen on the pins and in the flag bytes
    typedef struct packed {
        logic       holdover;
        logic       unlock;
        logic [3:0] freq_fault;
        logic [3:0] missing;
        logic [4:0] sys;
    } lmnsr_fault_t;

    typedef struct packed {
        logic                     detector_on;
        logic [1:0]               value_window;
        logic [3:0]               set_code;
        logic [3:0]               clear_code;
        logic                     timer_on;
        logic [`LMNSR_LEN_W-1:0]  clear_delay;
        logic                     extend_on;
        logic [`LMNSR_LEN_W-1:0]  extend_len;
        logic                     out_pass;
    } lmnsr_cfg_t;

endpackage : lmnsr_pkg

/* hdl/lmnsr_ppm_decode.sv */
// threshold code to ppm decoder, result in tenths of a ppm
// assumes a 4-bit code; codes above ten saturate at the top step
`timescale 1ns/10ps

module lmnsr_ppm_decode
    import lmnsr_pkg::*;
(
    // code in, threshold out
    input  wire logic [3:0]              code,
    output logic      [`LMNSR_PPM_W-1:0] tenth_ppm
);

    logic [3:0]              step;
    logic [`LMNSR_PPM_W-1:0] decade;

    always_comb
    begin
        // unused codes 11..15 read as the widest threshold rather than zero
        step = (code > `LMNSR_MAX_CODE) ? `LMNSR_MAX_CODE : code;
        case (step[3:1])
            3'h0:    decade = 17'h00001;
            3'h1:    decade = 17'h0000A;
            3'h2:    decade = 17'h00064;
            3'h3:    decade = 17'h003E8;
            3'h4:    decade = 17'h02710;
            default: decade = 17'h186A0;
        endcase
        // odd codes sit at three times the decade: 0.1, 0.3, 1, 3 ...
        tenth_ppm = step[0] ? `LMNSR_PPM_W'(decade * 3) : decade;
    end

endmodule : lmnsr_ppm_decode

/* test/tb_lmnsr_regs.sv */
// self-checking bench for the lock monitor register bank
// assumes the bank is alone on its register port and the bench plays the memory engine
`timescale 1ns/10ps

module tb_lmnsr_regs;
    import lmnsr_pkg::*;
    logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, nvm_burn_done = 0, nvm_load_valid = 0;
    logic nvm_reload_done = 0, nvm_burn_start, nvm_reload_start, irq, det_on, timer_on, ext_on;
    logic [15:0] reg_addr = 0, nvm_load_addr = 0;
    logic [7:0]  reg_wdata = 0, nvm_load_data = 0, reg_rdata;
    logic [7:0]  b [4];
    logic [16:0] set_thr, clr_thr;
    logic [28:0] delay, ext_len;
    logic [9:0]  drv_enable_in = 10'h3FF, drv_enable_out;
    logic [1:0]  value_window;
    lmnsr_fault_t fault_in = '0;
    int seed = 54, bad_count = 0, checks = 0;
    always #25 ref_clk = ~ref_clk;
    lmnsr_regs i_lmnsr_regs (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_burn_start(nvm_burn_start),
        .nvm_burn_done(nvm_burn_done), .nvm_reload_start(nvm_reload_start), .nvm_load_valid(nvm_load_valid),
        .nvm_load_addr(nvm_load_addr), .nvm_load_data(nvm_load_data), .nvm_reload_done(nvm_reload_done),
        .fault_in(fault_in), .slow_unlock_detector_on(det_on), .unlock_timer_on(timer_on),
        .value_window(value_window), .set_threshold_tenth_ppm(set_thr), .clear_threshold_tenth_ppm(clr_thr),
        .unlock_clear_delay(delay), .fast_acquire_extend_on(ext_on), .fast_acquire_extend_len(ext_len),
        .drv_enable_in(drv_enable_in), .drv_enable_out(drv_enable_out), .irq(irq));
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // strobes drop a full edge before the next access, so no signal is driven twice in one step
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 0;
        #1;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1 chk(reg_rdata, e, "rdata");
    endtask : rd
    // one-cycle pulse on a memory engine input: 0 burn done, 1 load valid, 2 reload done
    task pulse(input int n);
        @(posedge ref_clk);
        if (n == 0)
            nvm_burn_done <= 1;
        else if (n == 1)
            nvm_load_valid <= 1;
        else
            nvm_reload_done <= 1;
        @(posedge ref_clk);
        nvm_burn_done <= 0;
        nvm_load_valid <= 0;
        nvm_reload_done <= 0;
    endtask : pulse
    // threshold in tenths of a ppm: steps alternate x3 and x3.33
    function automatic logic [16:0] ppm(input int c);
        int v = 1;
        for (int i = 0; i < c / 2; i++) v *= 10;
        return (c % 2) ? 3 * v : v;
    endfunction : ppm
    task wrap_up;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        #300000 bad_count++;
        wrap_up();
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        reset <= 0;
        rd(16'h00E5, 8'h20);
        chk(drv_enable_out, 0, "drv off");
        rd(16'h00FE, 8'h0F);
        rd(16'h01FE, 8'h0F);
        rd(16'h00E2, 8'h00);
        for (int c = 0; c <= 10; c++)
        begin
            wr(16'h009E, c << 4); wr(16'h00A0, (10 - c) << 4);
            chk(set_thr, ppm(c), "set");
            chk(clr_thr, ppm(10 - c), "clear");
        end
        wr(16'h00A2, 8'h02); chk(timer_on, 0, "timer");
        wr(16'h009A, 8'h02); chk(timer_on, 1, "timer");
        chk(det_on, 1, "det on");
        wr(16'h009D, 8'h0C); chk(value_window, 2'h3, "window");
        wr(16'h00A2, 8'h00); chk(timer_on, 0, "timer");
        for (int k = 0; k < 4; k++)
        begin
            b[k] = $random(seed);
            wr(16'h00EA + k, b[k]); wr(16'h00A9 + k, b[k]);
        end
        chk(ext_len, {b[3][4:0], b[2], b[1], b[0]}, "ext len");
        chk(delay, {b[3][4:0], b[2], b[1], b[0]}, "delay");
        wr(16'h00E5, 8'h00); chk(ext_on, 0, "ext on");
        drv_enable_in <= $random(seed);
        wr(16'h0102, 8'h01); chk(drv_enable_out, drv_enable_in, "drv pass");
        // the fourth key must find the counter saturated
        for (int i = 0; i < 4; i++)
        begin
            wr(16'h00E3, 8'hC7); chk(nvm_burn_start, i < 3, "burn start");
            rd(16'h00FE, i < 3 ? 8'h00 : 8'h0F);
            pulse(0);
            rd(16'h00E2, i == 0 ? 8'h03 : i == 1 ? 8'h0F : 8'h3F);
        end
        wr(16'h0104, 8'hFF); wr(16'h0105, 8'h02);
        chk(irq, 0, "irq");
        wr(16'h00E4, 8'h01); chk(nvm_reload_start, 1, "reload start");
        rd(16'h00E4, 8'h01);
        nvm_load_addr <= 16'h0102; nvm_load_data <= 8'h00;
        pulse(1);
        pulse(2);
        rd(16'h00E4, 8'h00);
        chk(drv_enable_out, 0, "reloaded drv");
        chk(irq, 1, "irq");
        rd(16'h0104, 8'h02);
        wr(16'h0104, 8'h02); chk(irq, 0, "irq");
        fault_in.unlock <= 1;
        fault_in.sys[3] <= 1;
        fault_in.missing[2] <= 1;
        repeat (3) @(posedge ref_clk);
        rd(16'h00F7, 8'h10);
        rd(16'h00F8, 8'h04);
        rd(16'h00F9, 8'h02);
        rd(16'h00F6, 8'h07);
        wrap_up();
    end
endmodule : tb_lmnsr_regs
